// ### sadc_control.sv
// Slope converter control registers, conversion timer, capture and interrupt over AHB-Lite.
//
// Overview of operation
// - Two control registers at 1Fh and 9Fh, both readable and writable.
// - Control zero bits 7..4 select the multiplexer channel.
// - Control zero bit 3 is unimplemented and reads zero.
// - Bit 2 set drives the mux output onto port A bit 0, overriding direction.
// - Bit 1 set halts timer and discharges ramp; resets to one.
// - Bit 0 set enables zeroing on the two level-shifted inputs.
// - Control one bits 7..4 select ramp current; resets to zero, source off.
// - Control one bits 3..2 configure port D, bits 1..0 configure port A.
// - Code 00 all analog, 01 top pin digital, 10 top two, 11 all digital.
// - N-bit conversion takes 2^N oscillator periods, one timer step each.
// - Zeroing switches level-shift paths to present a zero-current condition.
// - Filter switch closed while sampling, opened automatically while zeroing.
// - Bandgap enabled only while sleep bit 5 is clear; it is channel 4.
// - Level shifters active while sleep bit 4 is zero, disabled when one.
// - 16-bit timer increments every clock while bit 1 is clear; reset clears it to zero.
// - Falling comparator output while bit 1 is clear captures the timer and sets the capture flag.
// - Channel codes 0000..1101 are used; 1110 and 1111 are reserved.
`include "sadc_defs.svh"
module sadc_control #(
	parameter int TIMER_WIDTH = 16
) (
	// Clock and reset.
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// AHB-Lite slave.
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// Analog front end.
	input  wire logic                   comparatorOut,
	output logic      [3:0]             channelSelect,
	output logic                        reservedChannel,
	output logic                        muxPinOutputEnable,
	output logic                        rampDischarge,
	output logic      [3:0]             rampCurrentSelect,
	output logic                        zeroSwitchEnable,
	output logic                        filterSwitchClosed,
	output logic                        bandgapEnable,
	output logic                        levelShiftEnable,
	output logic      [3:0]             portAAnalog,
	output logic      [3:0]             portDAnalog,
	// Interrupt.
	output logic                        irq
);

	// ****************************************************************
	// Bus slave.
	// ****************************************************************
	sadc_pkg::sadc_bus_type busState;
	logic [7:0] latchedAddr;
	logic       latchedWrite;
	logic       addrPhase;
	logic       writeNow;
	logic [7:0] ctrlZero;
	logic [7:0] ctrlOne;
	logic [7:0] sleepControl;
	logic [TIMER_WIDTH-1:0] conversionTimer;
	logic [TIMER_WIDTH-1:0] captureRegister;
	logic [1:0] status;
	logic [1:0] mask;
	logic       comparatorLast;
	logic       captureEvent;
	logic       overflowEvent;
	logic [31:0] next_hrdata;

	assign addrPhase = hsel && hready && htrans[1];
	assign writeNow = (busState == sadc_pkg::SADC_DATA) && latchedWrite;

	always_ff @(posedge mclk) begin
		if (rst) begin
			busState <= sadc_pkg::SADC_IDLE;
			latchedAddr <= 8'h00;
			latchedWrite <= 1'b0;
		end else begin
			busState <= addrPhase ? sadc_pkg::SADC_DATA : sadc_pkg::SADC_IDLE;
			if (addrPhase) begin
				// Each register is one word, so the index sits above the byte lane bits.
				latchedAddr <= haddr[9:2];
				latchedWrite <= hwrite;
			end
		end
	end

	// Zero wait states: every answer is OKAY and ready.
	always_ff @(posedge mclk) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read data is prepared in the address phase and stands in the data phase.
	always_comb begin
		next_hrdata = 32'h0000_0000;
		if (addrPhase && !hwrite) begin
			unique case (haddr[9:2])
				`SADC_CTRL0_ADDR: next_hrdata = {24'h00_0000, ctrlZero & `SADC_CTRL0_WMASK};
				`SADC_CTRL1_ADDR: next_hrdata = {24'h00_0000, ctrlOne};
				`SADC_SLEEP_ADDR: next_hrdata = {24'h00_0000, sleepControl};
				`SADC_TIMER_ADDR: next_hrdata = 32'(conversionTimer);
				`SADC_CAPT_ADDR:  next_hrdata = 32'(captureRegister);
				`SADC_STAT_ADDR:  next_hrdata = {30'h0000_0000, status};
				`SADC_MASK_ADDR:  next_hrdata = {30'h0000_0000, mask};
				default:          next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	// ****************************************************************
	// Control registers.
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlZero <= `SADC_CTRL0_RESET;
		end else if (writeNow && latchedAddr == `SADC_CTRL0_ADDR) begin
			ctrlZero <= hwdata[7:0] & `SADC_CTRL0_WMASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlOne <= `SADC_CTRL1_RESET;
		end else if (writeNow && latchedAddr == `SADC_CTRL1_ADDR) begin
			ctrlOne <= hwdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sleepControl <= `SADC_SLEEP_RESET;
		end else if (writeNow && latchedAddr == `SADC_SLEEP_ADDR) begin
			sleepControl <= hwdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mask <= 2'h0;
		end else if (writeNow && latchedAddr == `SADC_MASK_ADDR) begin
			mask <= hwdata[1:0];
		end
	end

	// ****************************************************************
	// Timer and capture.
	// ****************************************************************
	assign captureEvent = comparatorLast && !comparatorOut && !ctrlZero[`SADC_STOP_BIT];
	// A timer write in the wrapping cycle replaces the count, so it is no overflow.
	assign overflowEvent = !ctrlZero[`SADC_STOP_BIT] && (&conversionTimer) &&
		!(writeNow && latchedAddr == `SADC_TIMER_ADDR);

	always_ff @(posedge mclk) begin
		if (rst) begin
			comparatorLast <= 1'b0;
		end else begin
			comparatorLast <= comparatorOut;
		end
	end

	// Timer counts one step per clock while running, so N bits take 2^N cycles.
	always_ff @(posedge mclk) begin
		if (rst) begin
			conversionTimer <= TIMER_WIDTH'(`SADC_TIMER_RESET);
		end else if (writeNow && latchedAddr == `SADC_TIMER_ADDR) begin
			conversionTimer <= hwdata[TIMER_WIDTH-1:0];
		end else if (!ctrlZero[`SADC_STOP_BIT]) begin
			conversionTimer <= conversionTimer + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			captureRegister <= TIMER_WIDTH'(`SADC_TIMER_RESET);
		end else if (captureEvent) begin
			captureRegister <= conversionTimer;
		end else if (writeNow && latchedAddr == `SADC_CAPT_ADDR) begin
			captureRegister <= hwdata[TIMER_WIDTH-1:0];
		end
	end

	// ****************************************************************
	// Interrupt status: bit 0 capture, bit 1 overflow; set wins over clear.
	// ****************************************************************
	logic [1:0] clearBits;
	logic [1:0] setBits;
	assign clearBits = (writeNow && latchedAddr == `SADC_STAT_ADDR) ? hwdata[1:0] : 2'h0;
	assign setBits = {overflowEvent, captureEvent};

	always_ff @(posedge mclk) begin
		if (rst) begin
			status <= 2'h0;
		end else begin
			status <= (status & ~clearBits) | setBits;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((status & ~clearBits) | setBits) & mask);
		end
	end

	// ****************************************************************
	// Analog controls, each registered from the control and sleep registers.
	// ****************************************************************
	logic [7:0] next_ctrlZero;
	logic [7:0] next_ctrlOne;
	logic [7:0] next_sleep;
	assign next_ctrlZero = (writeNow && latchedAddr == `SADC_CTRL0_ADDR) ?
		(hwdata[7:0] & `SADC_CTRL0_WMASK) : ctrlZero;
	assign next_ctrlOne = (writeNow && latchedAddr == `SADC_CTRL1_ADDR) ? hwdata[7:0] : ctrlOne;
	assign next_sleep = (writeNow && latchedAddr == `SADC_SLEEP_ADDR) ? hwdata[7:0] : sleepControl;

	always_ff @(posedge mclk) begin
		if (rst) begin
			channelSelect <= 4'(`SADC_CTRL0_RESET >> `SADC_CHAN_LSB);
			reservedChannel <= 1'b0;
			muxPinOutputEnable <= 1'b0;
			rampDischarge <= 1'b1;
			zeroSwitchEnable <= 1'b0;
			filterSwitchClosed <= 1'b0;
		end else begin
			channelSelect <= next_ctrlZero[`SADC_CHAN_MSB:`SADC_CHAN_LSB];
			reservedChannel <= next_ctrlZero[`SADC_CHAN_MSB:`SADC_CHAN_LSB] >
				`SADC_CHAN_LASTUSED;
			muxPinOutputEnable <= next_ctrlZero[`SADC_MUXOE_BIT];
			rampDischarge <= next_ctrlZero[`SADC_STOP_BIT];
			zeroSwitchEnable <= next_ctrlZero[`SADC_ZERO_BIT];
			filterSwitchClosed <= !next_ctrlZero[`SADC_ZERO_BIT] &&
				!next_ctrlZero[`SADC_STOP_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rampCurrentSelect <= 4'h0;
			bandgapEnable <= 1'b1;
			levelShiftEnable <= 1'b1;
		end else begin
			rampCurrentSelect <= next_ctrlOne[`SADC_RAMP_MSB:`SADC_RAMP_LSB];
			bandgapEnable <= !next_sleep[`SADC_BGOFF_BIT];
			levelShiftEnable <= !next_sleep[`SADC_LEVEL_SHIFT_DISABLE_BIT];
		end
	end

	// Code k makes the top k pins digital; code 3 makes all four digital.
	genvar pin;
	generate
		for (pin = 0; pin < 4; pin++) begin : g_port
			always_ff @(posedge mclk) begin
				if (rst) begin
					portAAnalog[pin] <= 1'b1;
					portDAnalog[pin] <= 1'b1;
				end else begin
					portAAnalog[pin] <= (next_ctrlOne[`SADC_PORTA_MSB:`SADC_PORTA_LSB] == 2'h3) ? 1'b0 :
						(pin < 4 - next_ctrlOne[`SADC_PORTA_MSB:`SADC_PORTA_LSB]);
					portDAnalog[pin] <= (next_ctrlOne[`SADC_PORTD_MSB:`SADC_PORTD_LSB] == 2'h3) ? 1'b0 :
						(pin < 4 - next_ctrlOne[`SADC_PORTD_MSB:`SADC_PORTD_LSB]);
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	a_bit3_reads_zero: assert property (@(posedge mclk) disable iff (rst)
		!ctrlZero[3]) else $error("Control zero bit 3 stored a one.");
	a_timer_halts: assert property (@(posedge mclk) disable iff (rst)
		ctrlZero[`SADC_STOP_BIT] && !writeNow |=> $stable(conversionTimer))
		else $error("Timer moved while stopped.");
	a_timer_counts: assert property (@(posedge mclk) disable iff (rst)
		!ctrlZero[`SADC_STOP_BIT] && !writeNow |=> conversionTimer == $past(conversionTimer) + 1'b1)
		else $error("Timer did not step by one.");
	a_capture_value: assert property (@(posedge mclk) disable iff (rst)
		captureEvent |=> captureRegister == $past(conversionTimer) && status[0])
		else $error("Capture missed timer value or flag.");
	a_filter_open: assert property (@(posedge mclk) disable iff (rst)
		zeroSwitchEnable |-> !filterSwitchClosed) else $error("Filter switch closed while zeroing.");
	a_ctrl_follows: assert property (@(posedge mclk) disable iff (rst)
		busState == sadc_pkg::SADC_DATA ##0 1'b1 |=> channelSelect == ctrlZero[7:4])
		else $error("Channel select does not follow control zero.");
	a_portd_all: assert property (@(posedge mclk) disable iff (rst)
		ctrlOne[3:2] == 2'h0 ##1 ctrlOne[3:2] == 2'h0 |-> portDAnalog == 4'hF)
		else $error("Port D code 00 not all analog.");
	a_bandgap_off: assert property (@(posedge mclk) disable iff (rst)
		sleepControl[5] ##1 sleepControl[5] |-> !bandgapEnable) else $error("Bandgap on while disabled.");

	// ****************************************************************
	// Bus, timer and interrupt assertions.
	// ****************************************************************
	a_bus_okay: assert property (@(posedge mclk) disable iff (rst)
		hreadyout && !hresp) else $error("Slave left ready or OKAY.");
	a_ctrl0_read: assert property (@(posedge mclk) disable iff (rst)
		busState == sadc_pkg::SADC_DATA && !latchedWrite &&
		latchedAddr == `SADC_CTRL0_ADDR |-> !hrdata[3])
		else $error("Control zero bit 3 read as one.");
	a_ctrl0_store: assert property (@(posedge mclk) disable iff (rst)
		writeNow && latchedAddr == `SADC_CTRL0_ADDR |=> !ctrlZero[3] && ctrlZero[7:4] == $past(hwdata[7:4]))
		else $error("Control zero write stored the wrong bits.");
	a_ctrl1_store: assert property (@(posedge mclk) disable iff (rst)
		writeNow && latchedAddr == `SADC_CTRL1_ADDR |=> ctrlOne == $past(hwdata[7:0]))
		else $error("Control one write not stored.");
	a_capture_hold: assert property (@(posedge mclk) disable iff (rst)
		!captureEvent && !writeNow |=> $stable(captureRegister))
		else $error("Capture register moved without an event.");
	a_overflow_flag: assert property (@(posedge mclk) disable iff (rst)
		overflowEvent |=> status[1])
		else $error("Overflow did not set its status bit.");
	a_irq_level: assert property (@(posedge mclk) disable iff (rst)
		|(status & mask) && !writeNow |=> irq)
		else $error("Interrupt low with an unmasked flag set.");
	a_irq_quiet: assert property (@(posedge mclk) disable iff (rst)
		status == 2'h0 && setBits == 2'h0 |=> !irq)
		else $error("Interrupt high with no flag set.");

	// ****************************************************************
	// Analog control assertions.
	// ****************************************************************
	a_mux_enable: assert property (@(posedge mclk) disable iff (rst)
		muxPinOutputEnable == ctrlZero[`SADC_MUXOE_BIT])
		else $error("Mux pin enable differs from its control bit.");
	a_ramp_discharge: assert property (@(posedge mclk) disable iff (rst)
		rampDischarge == ctrlZero[`SADC_STOP_BIT])
		else $error("Ramp discharge differs from the stop bit.");
	a_zero_switch: assert property (@(posedge mclk) disable iff (rst)
		zeroSwitchEnable == ctrlZero[`SADC_ZERO_BIT])
		else $error("Zero switch differs from its control bit.");
	a_filter_closed: assert property (@(posedge mclk) disable iff (rst)
		!ctrlZero[`SADC_ZERO_BIT] && !ctrlZero[`SADC_STOP_BIT] |-> filterSwitchClosed)
		else $error("Filter switch open while sampling.");
	a_reserved_code: assert property (@(posedge mclk) disable iff (rst)
		reservedChannel == (channelSelect > `SADC_CHAN_LASTUSED))
		else $error("Reserved channel flag wrong.");
	a_ramp_current: assert property (@(posedge mclk) disable iff (rst)
		rampCurrentSelect == ctrlOne[`SADC_RAMP_MSB:`SADC_RAMP_LSB])
		else $error("Ramp current differs from control one.");
	a_porta_digital: assert property (@(posedge mclk) disable iff (rst)
		ctrlOne[`SADC_PORTA_MSB:`SADC_PORTA_LSB] == 2'h3 |-> portAAnalog == 4'h0)
		else $error("Port A code 11 not all digital.");
	a_porta_top: assert property (@(posedge mclk) disable iff (rst)
		ctrlOne[`SADC_PORTA_MSB:`SADC_PORTA_LSB] == 2'h1 |-> portAAnalog == 4'h7)
		else $error("Port A code 01 not top pin digital.");
	a_portd_top: assert property (@(posedge mclk) disable iff (rst)
		ctrlOne[`SADC_PORTD_MSB:`SADC_PORTD_LSB] == 2'h2 |-> portDAnalog == 4'h3)
		else $error("Port D code 10 not top two pins digital.");
	a_level_shift: assert property (@(posedge mclk) disable iff (rst)
		levelShiftEnable == !sleepControl[`SADC_LEVEL_SHIFT_DISABLE_BIT])
		else $error("Level shift enable differs from its sleep bit.");
	a_bandgap_on: assert property (@(posedge mclk) disable iff (rst)
		!sleepControl[`SADC_BGOFF_BIT] |-> bandgapEnable)
		else $error("Bandgap off while enabled.");
endmodule

// ### sadc_defs.svh
// Register offsets, field positions, reset values and channel codes of the slope converter control.
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH
// Register addresses are word indices; the byte address on the bus is four times the index.
`define SADC_CTRL0_ADDR    8'h1F
`define SADC_CTRL1_ADDR    8'h9F
`define SADC_SLEEP_ADDR    8'hA0
`define SADC_TIMER_ADDR    8'hA4
`define SADC_CAPT_ADDR     8'hA8
`define SADC_STAT_ADDR     8'hAC
`define SADC_MASK_ADDR     8'hB0
`define SADC_CTRL0_RESET   8'h02
`define SADC_CTRL1_RESET   8'h00
`define SADC_SLEEP_RESET   8'h00
`define SADC_CTRL0_WMASK   8'hF7
`define SADC_CHAN_MSB      7
`define SADC_CHAN_LSB      4
`define SADC_MUXOE_BIT     2
`define SADC_STOP_BIT      1
`define SADC_ZERO_BIT      0
`define SADC_RAMP_MSB      7
`define SADC_RAMP_LSB      4
`define SADC_PORTD_MSB     3
`define SADC_PORTD_LSB     2
`define SADC_PORTA_MSB     1
`define SADC_PORTA_LSB     0
`define SADC_BGOFF_BIT     5
`define SADC_LEVEL_SHIFT_DISABLE_BIT     4
`define SADC_CHAN_BANDGAP  4'h4
`define SADC_CHAN_SHIFT1   4'h1
`define SADC_CHAN_SHIFT2   4'hB
`define SADC_CHAN_LASTUSED 4'hD
`define SADC_TIMER_RESET   16'h0000
`endif

// ### sadc_pkg.sv
// Types shared by the slope converter control.
package sadc_pkg;
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b01,
		SADC_DATA = 2'b10
	} sadc_bus_type;
endpackage

// ### sadc_ramp_model.sv
// Ramp capacitor and comparator model standing beside the converter control.
module sadc_ramp_model #(
	parameter int TRIP = 20
) (
	// Control from the converter.
	input  wire logic       mclk,
	input  wire logic       rampDischarge,
	input  wire logic [3:0] rampCurrentSelect,
	// Comparator level.
	output logic            comparatorOut
);
	timeunit 1ns;
	timeprecision 1ps;
	int rampLevel;
	// The ramp charges by the selected current each cycle and is emptied while held.
	always_ff @(posedge mclk) begin
		if (rampDischarge) begin
			rampLevel <= 0;
		end else begin
			rampLevel <= rampLevel + int'(rampCurrentSelect);
		end
	end
	assign comparatorOut = (rampLevel < TRIP);
endmodule

// ### sadc_control_test.sv
// Self-checking bench of the slope converter control over AHB-Lite.
`include "sadc_defs.svh"
module sadc_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, rst = 1, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv, t0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, comparatorOut, reservedChannel, muxPinOutputEnable;
	logic        rampDischarge, zeroSwitchEnable, filterSwitchClosed, bandgapEnable;
	logic        levelShiftEnable, irq;
	logic [3:0]  channelSelect, rampCurrentSelect, portAAnalog, portDAnalog;
	int          failures = 0, num_checks = 0;
	sadc_control u_sadc_control (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.comparatorOut(comparatorOut), .channelSelect(channelSelect),
		.reservedChannel(reservedChannel), .muxPinOutputEnable(muxPinOutputEnable),
		.rampDischarge(rampDischarge), .rampCurrentSelect(rampCurrentSelect),
		.zeroSwitchEnable(zeroSwitchEnable), .filterSwitchClosed(filterSwitchClosed),
		.bandgapEnable(bandgapEnable), .levelShiftEnable(levelShiftEnable),
		.portAAnalog(portAAnalog), .portDAnalog(portDAnalog), .irq(irq));
	sadc_ramp_model u_sadc_ramp_model (.mclk(mclk), .rampDischarge(rampDischarge),
		.rampCurrentSelect(rampCurrentSelect), .comparatorOut(comparatorOut));
	always #5 mclk = ~mclk;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic readyEdge();
		do begin
			@(posedge mclk);
		end while (hreadyout !== 1'b1);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {22'h00_0000, a, 2'b00};
		readyEdge();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		readyEdge();
		rdv = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(what, rdv, exp);
	endtask
	// Lets the control outputs follow a finished write.
	task automatic settle();
		repeat (2) @(posedge mclk);
	endtask
	task automatic testReset();
		rd("ctrl0", `SADC_CTRL0_ADDR, 32'h0000_0002);
		rd("ctrl1", `SADC_CTRL1_ADDR, 32'h0000_0000);
		rd("timer", `SADC_TIMER_ADDR, 32'h0000_0000);
		check("discharge", rampDischarge, 1'b1);
		check("current", rampCurrentSelect, 4'h0);
		check("bandgap", bandgapEnable, 1'b1);
		check("shift", levelShiftEnable, 1'b1);
		check("porta", portAAnalog, 4'hF);
		check("portd", portDAnalog, 4'hF);
		check("irq", irq, 1'b0);
	endtask
	task automatic testConversion();
		wr(`SADC_MASK_ADDR, 32'h0000_0001);
		wr(`SADC_CTRL1_ADDR, 32'h0000_0010);
		repeat (20000) @(posedge mclk);
		wr(`SADC_CTRL0_ADDR, 32'h0000_0040);
		settle();
		check("discharge", rampDischarge, 1'b0);
		check("chan", channelSelect, `SADC_CHAN_BANDGAP);
		check("reserved", reservedChannel, 1'b0);
		for (int n = 0; n < 60 && irq !== 1'b1; n++) @(posedge mclk);
		check("irq", irq, 1'b1);
		bus(1'b0, `SADC_CAPT_ADDR, 32'h0000_0000);
		check("capture", 32'(rdv >= 18 && rdv <= 24), 32'h1);
		rd("status", `SADC_STAT_ADDR, 32'h0000_0001);
		wr(`SADC_MASK_ADDR, 32'h0000_0000);
		settle();
		check("masked", irq, 1'b0);
		wr(`SADC_MASK_ADDR, 32'h0000_0001);
		settle();
		check("unmasked", irq, 1'b1);
		wr(`SADC_STAT_ADDR, 32'h0000_0001);
		settle();
		check("cleared", irq, 1'b0);
		rd("status", `SADC_STAT_ADDR, 32'h0000_0000);
	endtask
	task automatic testCtrl0();
		wr(`SADC_CTRL0_ADDR, 32'h0000_00FF);
		rd("ctrl0", `SADC_CTRL0_ADDR, 32'h0000_00F7);
		settle();
		check("chan", channelSelect, 4'hF);
		check("reserved", reservedChannel, 1'b1);
		check("muxoe", muxPinOutputEnable, 1'b1);
		check("zero", zeroSwitchEnable, 1'b1);
		check("filter", filterSwitchClosed, 1'b0);
		check("discharge", rampDischarge, 1'b1);
		wr(`SADC_CTRL0_ADDR, 32'h0000_00E8);
		rd("ctrl0", `SADC_CTRL0_ADDR, 32'h0000_00E0);
		check("reserved", reservedChannel, 1'b1);
		check("muxoe", muxPinOutputEnable, 1'b0);
		check("zero", zeroSwitchEnable, 1'b0);
		check("filter", filterSwitchClosed, 1'b1);
		bus(1'b0, `SADC_TIMER_ADDR, 32'h0000_0000);
		t0 = rdv;
		bus(1'b0, `SADC_TIMER_ADDR, 32'h0000_0000);
		check("running", rdv - t0, 32'h0000_0002);
		wr(`SADC_CTRL0_ADDR, 32'h0000_0002);
		bus(1'b0, `SADC_TIMER_ADDR, 32'h0000_0000);
		t0 = rdv;
		rd("stopped", `SADC_TIMER_ADDR, t0);
	endtask
	task automatic testOverflow();
		wr(`SADC_CTRL0_ADDR, 32'h0000_0002);
		wr(`SADC_STAT_ADDR, 32'h0000_0003);
		wr(`SADC_TIMER_ADDR, 32'h0000_FFF8);
		rd("timer", `SADC_TIMER_ADDR, 32'h0000_FFF8);
		wr(`SADC_CTRL0_ADDR, 32'h0000_0000);
		repeat (12) @(posedge mclk);
		bus(1'b0, `SADC_STAT_ADDR, 32'h0000_0000);
		check("overflow", rdv & 32'h0000_0002, 32'h0000_0002);
		wr(`SADC_CTRL0_ADDR, 32'h0000_0002);
	endtask
	task automatic testCtrl1();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(`SADC_CTRL1_ADDR, {24'h0000_00, c, ~c, c, ~c});
			rd("ctrl1", `SADC_CTRL1_ADDR, {24'h0000_00, c, ~c, c, ~c});
			check("current", rampCurrentSelect, {c, ~c});
			check("portd", portDAnalog, (c == 2'd3) ? 4'h0 : 4'hF >> c);
			check("porta", portAAnalog, (c == 2'd0) ? 4'h0 : 4'hF >> ~c);
		end
	endtask
	task automatic testSleep();
		wr(`SADC_SLEEP_ADDR, 32'h0000_0020);
		settle();
		check("bandgap", bandgapEnable, 1'b0);
		check("shift", levelShiftEnable, 1'b1);
		wr(`SADC_SLEEP_ADDR, 32'h0000_0010);
		settle();
		check("bandgap", bandgapEnable, 1'b1);
		check("shift", levelShiftEnable, 1'b0);
		wr(8'hC0, 32'hFFFF_FFFF);
		rd("unmapped", 8'hC0, 32'h0000_0000);
		check("resp", hresp, 1'b0);
		check("ready", hreadyout, 1'b1);
	endtask
	task automatic close_out();
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		testReset();
		testConversion();
		testCtrl0();
		testOverflow();
		testCtrl1();
		testSleep();
		close_out();
	end
endmodule
